// ### src_reset_ctrl.v
// System reset controller: gathers sources and drives the system reset
`include "srcrst_defines.vh"
`default_nettype none
module src_reset_ctrl #(
    parameter NUM_SRC = `SRC_NUM_SRC,
    parameter SYNC_STAGES = `SRC_SYNC_STAGES
) (
    input wire I_CLK,
    input wire I_RESET_N,
    input wire i_por,
    input wire i_ext_pin_n,
    input wire i_cmp_rst,
    input wire i_sw_rst,
    input wire i_supply_rst,
    input wire i_wdg_ovf,
    input wire i_missing_clk,
    input wire i_flash_err,
    input wire i_tku_alarm,
    input wire i_tku_osc_fail,
    output wire O_SYS_RST_N,
    output wire O_POR_RST_N,
    output wire O_CORE_HALT,
    output wire O_RAM_HOLD,
    output wire O_PORT_LATCH_SET,
    output wire O_PORT_OPEN_DRAIN,
    output wire O_PULLUP_EN,
    output wire O_IRQ_DISABLE,
    output wire O_TIMER_DISABLE,
    output wire O_EXT_RESET_PIN_N_OUT,
    output wire O_EXT_RESET_PIN_N_OE_N,
    output wire [15:0] O_PC_LOAD,
    output wire O_PC_LOAD_EN,
    output wire [1:0] O_CLKSEL,
    output wire O_CLKSEL_LOAD,
    output wire O_WDG_ENABLE,
    output wire [2:0] O_WDG_INTERVAL,
    output wire O_WDG_LOAD,
    output wire [NUM_SRC-1:0] O_RESET_CAUSE
);
    wire [NUM_SRC-1:0] src_vec;
    wire any_src;
    wire arst_n;
    wire sys_rst_n;
    wire por_arst_n;
    wire por_rst_n;
    reg in_rst_reg;
    reg drive_pin_reg;
    reg [NUM_SRC-1:0] cause_reg;

    assign src_vec = {i_tku_osc_fail, i_tku_alarm, i_flash_err, i_missing_clk, i_wdg_ovf,
                      i_supply_rst, i_sw_rst, i_cmp_rst, ~i_ext_pin_n, i_por};
    assign any_src = |src_vec;
    assign arst_n = I_RESET_N & ~any_src;
    assign por_arst_n = I_RESET_N & ~i_por;

    src_sync_release #(.STAGES(SYNC_STAGES)) u_sys_sync (
        .i_clk(I_CLK),
        .i_arst_n(arst_n),
        .o_rst_n(sys_rst_n)
    );
    src_sync_release #(.STAGES(SYNC_STAGES)) u_por_sync (
        .i_clk(I_CLK),
        .i_arst_n(por_arst_n),
        .o_rst_n(por_rst_n)
    );

    // Pin drive latched per episode; a watchdog episode drives only if power-on or supply also asserts in it
    always @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            in_rst_reg <= 1'b1;
            drive_pin_reg <= 1'b1;
            cause_reg <= {NUM_SRC{1'b0}};
        end else begin
            in_rst_reg <= ~sys_rst_n;
            if (!sys_rst_n) begin
                if (src_vec[`SRC_SRC_POR] | src_vec[`SRC_SRC_SUP]) begin
                    drive_pin_reg <= 1'b1;
                end
                // Sources assert asynchronously, so the episode start is seen via in_rst_reg
                if (in_rst_reg) begin
                    cause_reg <= cause_reg | src_vec;
                end else begin
                    cause_reg <= src_vec;
                end
            end else begin
                drive_pin_reg <= 1'b0;
            end
        end
    end

    assign O_SYS_RST_N = sys_rst_n;
    assign O_POR_RST_N = por_rst_n;
    assign O_CORE_HALT = ~sys_rst_n;
    assign O_RAM_HOLD = 1'b1;
    assign O_PORT_LATCH_SET = ~sys_rst_n;
    assign O_PORT_OPEN_DRAIN = ~sys_rst_n;
    // pullups stay enabled; software may change them later
    assign O_PULLUP_EN = 1'b1;
    assign O_IRQ_DISABLE = ~sys_rst_n;
    assign O_TIMER_DISABLE = ~sys_rst_n;
    assign O_EXT_RESET_PIN_N_OUT = 1'b0;
    assign O_EXT_RESET_PIN_N_OE_N = ~(drive_pin_reg & ~sys_rst_n);
    assign O_PC_LOAD = `SRC_PC_RESET;
    // in_rst_reg lags the release by one edge: one load cycle after reset
    assign O_PC_LOAD_EN = ~sys_rst_n | in_rst_reg;
    assign O_CLKSEL = `SRC_CLKSEL_INT;
    assign O_CLKSEL_LOAD = ~sys_rst_n;
    assign O_WDG_ENABLE = 1'b1;
    assign O_WDG_INTERVAL = `SRC_WDG_MAX_IVL;
    assign O_WDG_LOAD = ~sys_rst_n;
    assign O_RESET_CAUSE = cause_reg;
endmodule // src_reset_ctrl
`default_nettype wire

// ### srcrst_defines.vh
// Constants of the system reset controller
// Notes on behaviour
// - Any of ten sources enters reset
// - Core halted while reset active
// - Registers reset except power-on-only bits
// - Reset never touches RAM contents
// - Port latches preset to one, open-drain
// - Weak pullups on during, after reset
// - Reset disables interrupts and timers
// - Pin driven low for supply/power-on
// - Program counter cleared to 0x0000
// - Clock selection returns to internal oscillator
// - Watchdog enabled on leaving reset
// - Watchdog reset leaves pin undriven; code drives it if power-on or supply joins the episode
// - Watchdog timeout set to longest interval
`ifndef SRC_DEFINES_VH
`define SRC_DEFINES_VH
`define SRC_NUM_SRC 10
`define SRC_SRC_POR 0
`define SRC_SRC_PIN 1
`define SRC_SRC_CMP 2
`define SRC_SRC_SW 3
`define SRC_SRC_SUP 4
`define SRC_SRC_WDG 5
`define SRC_SRC_MCD 6
`define SRC_SRC_FLE 7
`define SRC_SRC_TKA 8
`define SRC_SRC_TKF 9
`define SRC_PC_RESET 16'h0000
`define SRC_CLKSEL_INT 2'h0
`define SRC_WDG_MAX_IVL 3'h7
`define SRC_SYNC_STAGES 2
`endif

// ### src_sync_release.v
// Reset release synchroniser: asserts at once, releases on a clock edge
`default_nettype none
module src_sync_release #(
    parameter STAGES = 2
) (
    input wire i_clk,
    input wire i_arst_n,
    output wire o_rst_n
);
    reg [STAGES-1:0] chain_reg;
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            chain_reg <= {STAGES{1'b0}};
        end else begin
            chain_reg <= {chain_reg[STAGES-2:0], 1'b1};
        end
    end
    assign o_rst_n = chain_reg[STAGES-1];
endmodule // src_sync_release
`default_nettype wire

// ### srcrst_src_model.sv
// Model of the reset sources facing the controller
`default_nettype none
module srcrst_src_model(input wire logic [9:0] req, output logic [9:0] src);
    timeunit 1ns;
    timeprecision 1ns;
    // Requests already change off the sampling edge, so no extra delay
    always_comb src = req;
endmodule // srcrst_src_model
`default_nettype wire

// ### srcrst_checker.sv
// Checker on the reset controller ports
`default_nettype none
module srcrst_checker(input wire logic I_CLK, I_RESET_N, i_sw_rst, i_supply_rst,
    i_wdg_ovf, O_SYS_RST_N, O_POR_RST_N, O_CORE_HALT, O_RAM_HOLD, O_PULLUP_EN,
    O_EXT_RESET_PIN_N_OE_N, O_PC_LOAD_EN, O_PORT_LATCH_SET, O_PORT_OPEN_DRAIN,
    O_IRQ_DISABLE, O_TIMER_DISABLE, O_CLKSEL_LOAD, O_WDG_ENABLE, O_WDG_LOAD,
    input wire logic [1:0] O_CLKSEL,
    input wire logic [2:0] O_WDG_INTERVAL,
    input wire logic [15:0] O_PC_LOAD);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RESET_N);
    chk_src_entry: assert property (i_wdg_ovf |-> !O_SYS_RST_N)
        else $error("entry");
    chk_core_halt: assert property (O_CORE_HALT == !O_SYS_RST_N)
        else $error("halt");
    chk_por_bits: assert property (i_sw_rst |-> O_POR_RST_N)
        else $error("por");
    chk_hold_on: assert property (!O_SYS_RST_N |-> O_RAM_HOLD && O_PULLUP_EN)
        else $error("hold");
    chk_pin_drive: assert property (i_supply_rst |=> !O_EXT_RESET_PIN_N_OE_N)
        else $error("pin");
    chk_pc_pulse: assert property ($rose(O_SYS_RST_N) |-> O_PC_LOAD_EN ##1 !O_PC_LOAD_EN)
        else $error("pc");
    chk_wdg_nopin: assert property ($rose(i_wdg_ovf) && $past(O_SYS_RST_N) |=>
        O_EXT_RESET_PIN_N_OE_N)
        else $error("wdg");
    chk_rel_sync: assert property ($rose(O_SYS_RST_N) |-> !$past(i_wdg_ovf, 2))
        else $error("sync");
    chk_port_preset: assert property (!O_SYS_RST_N |-> O_PORT_LATCH_SET && O_PORT_OPEN_DRAIN)
        else $error("port");
    chk_irq_timer: assert property (!O_SYS_RST_N |-> O_IRQ_DISABLE && O_TIMER_DISABLE)
        else $error("irq");
    chk_pc_zero: assert property (O_PC_LOAD_EN |-> O_PC_LOAD == 16'h0000)
        else $error("pcval");
    chk_clk_int: assert property (!O_SYS_RST_N |-> O_CLKSEL_LOAD && O_CLKSEL == 2'h0)
        else $error("clk");
    chk_wdg_long: assert property (!O_SYS_RST_N |-> O_WDG_LOAD && O_WDG_ENABLE && O_WDG_INTERVAL == 3'h7)
        else $error("wdgcfg");
    cover property ($rose(O_SYS_RST_N));
    cover property (i_supply_rst);
    cover property (i_wdg_ovf && i_sw_rst);
endmodule // srcrst_checker
bind src_reset_ctrl srcrst_checker srcrst_checker_i(.*);
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the reset controller
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic I_CLK = 0;
    logic I_RESET_N = 0;
    logic [9:0] req = '0;
    wire [9:0] s, ca;
    wire sn, oe, pe;
    int n_errors = 0;
    int samples_checked = 0;
    srcrst_src_model srcrst_src_model_i(.req(req),.src(s));
    src_reset_ctrl src_reset_ctrl_i(.I_CLK(I_CLK),.I_RESET_N(I_RESET_N),.i_por(s[0]),
    .i_ext_pin_n(~s[1]),.i_cmp_rst(s[2]),.i_sw_rst(s[3]),.i_supply_rst(s[4]),
    .i_wdg_ovf(s[5]),.i_missing_clk(s[6]),.i_flash_err(s[7]),.i_tku_alarm(s[8]),
    .i_tku_osc_fail(s[9]),.O_SYS_RST_N(sn),.O_POR_RST_N(),.O_CORE_HALT(),.O_RAM_HOLD(),
    .O_PORT_LATCH_SET(),.O_PORT_OPEN_DRAIN(),.O_PULLUP_EN(),.O_IRQ_DISABLE(),
    .O_TIMER_DISABLE(),.O_EXT_RESET_PIN_N_OUT(),.O_EXT_RESET_PIN_N_OE_N(oe),.O_PC_LOAD(),
    .O_PC_LOAD_EN(pe),.O_CLKSEL(),.O_CLKSEL_LOAD(),.O_WDG_ENABLE(),.O_WDG_INTERVAL(),
    .O_WDG_LOAD(),.O_RESET_CAUSE(ca));
    initial forever #50 I_CLK = ~I_CLK;
    task automatic cmp(input string nm, input logic [9:0] e, g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic t_each;
        for (int k = 0; k < 10; k++) begin
            @(negedge I_CLK) req = 10'h1 << k;
            @(negedge I_CLK) req = '0;
            cmp("sys_n", 0, sn);
            cmp("cause", 10'h1 << k, ca);
            cmp("oe_n", (k == 0 || k == 4) ? 0 : 1, oe);
            @(negedge I_CLK) cmp("sys_n", 0, sn);
            @(negedge I_CLK) cmp("sys_n", 1, sn);
            cmp("pc_en", 1, pe);
            @(negedge I_CLK) cmp("pc_en", 0, pe);
        end
        $display("each source done");
    endtask
    task automatic t_both;
        @(negedge I_CLK) req = 10'h028;
        @(negedge I_CLK) req = 10'h008;
        repeat (3) @(negedge I_CLK);
        cmp("sys_n", 0, sn);
        cmp("cause", 10'h028, ca);
        req = '0;
        repeat (2) @(negedge I_CLK);
        cmp("sys_n", 1, sn);
        $display("overlap done");
    endtask
    initial begin
        repeat (2) @(negedge I_CLK);
        I_RESET_N = 1;
        repeat (3) @(negedge I_CLK);
        t_each;
        t_both;
        wrap_up;
    end
endmodule // tb_top
`default_nettype wire
